// ### rtl/drive_supervisor_pkg.sv
// Shared constants, register map and carrier types for the drive supervisor
package drive_supervisor_pkg;

  // ************
  // Timing
  // ************
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OT_STEP_MS = 100;
  localparam int unsigned OT_STEP_CYCLES = OT_STEP_MS * CLK_MHZ * 1000;

  // ************
  // Register map
  // ************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACCEL_LVL = 8'h04;
  localparam logic [7:0] OFF_CONST_LVL = 8'h08;
  localparam logic [7:0] OFF_DECEL_LVL = 8'h0C;
  localparam logic [7:0] OFF_OT_LVL = 8'h10;
  localparam logic [7:0] OFF_OT_TIME = 8'h14;
  localparam logic [7:0] OFF_STALL_DEC = 8'h18;
  localparam logic [7:0] OFF_RATED_CUR = 8'h1C;
  localparam logic [7:0] OFF_OV_VOLT = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN = 8'h28;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h2C;
  localparam logic [7:0] OFF_MONITOR = 8'h30;
  localparam logic [7:0] OFF_SAVED = 8'h34;
  localparam logic [7:0] OFF_FREQ_BASE = 8'h40;
  localparam logic [7:0] OFF_TIMER_BASE = 8'h80;

  // ************
  // Fields
  // ************
  localparam int unsigned CTRL_OV_EN = 0;
  localparam int unsigned CTRL_OT_MODE = 1;
  localparam int unsigned CTRL_RETAIN = 3;
  localparam int unsigned CTRL_MS_MODE = 4;
  localparam logic [2:0] MS_INTERNAL = 3'h1;
  localparam int unsigned EV_OV_HOLD = 0;
  localparam int unsigned EV_ACC_HOLD = 1;
  localparam int unsigned EV_CONST_RED = 2;
  localparam int unsigned EV_OT_ALARM = 3;
  localparam int unsigned EV_OT_TRIP = 4;
  localparam int unsigned EV_SAVED = 5;
  localparam int unsigned NUM_EV = 6;
  localparam int unsigned NUM_FREQ = 15;
  localparam int unsigned NUM_TIMER = 16;
  localparam logic [23:0] PCT_FULL = 24'h000064;

  // ************
  // Reset values
  // ************
  localparam logic [6:0] CTRL_RST = 7'h01;
  localparam logic [7:0] ACCEL_LVL_RST = 8'h96;
  localparam logic [7:0] CONST_LVL_RST = 8'h00;
  localparam logic [7:0] DECEL_LVL_RST = 8'h96;
  localparam logic [7:0] OT_LVL_RST = 8'h00;
  localparam logic [7:0] OT_TIME_RST = 8'h0A;
  localparam logic [15:0] STALL_DEC_RST = 16'h0032;
  localparam logic [15:0] RATED_CUR_RST = 16'h0064;
  localparam logic [15:0] OV_VOLT_RST = 16'h0320;
  // Step 2 first, in 0.01 Hz
  localparam logic [NUM_FREQ-1:0][15:0] FREQ_RST = {
    16'h1194, 16'h0FA0, 16'h0DAC, 16'h0BB8, 16'h09C4, 16'h07D0, 16'h05DC,
    16'h03E8, 16'h0032, 16'h0FA0, 16'h0DAC, 16'h0BB8, 16'h09C4, 16'h07D0,
    16'h05DC};
  // Timer 1 first, in 0.1 s
  localparam logic [NUM_TIMER-1:0][15:0] TIMER_RST = {
    {14{16'h0000}}, 16'h0064, 16'h0064};

  // ************
  // Types
  // ************
  typedef enum logic [1:0] {
    OT_IDLE = 2'b00,
    OT_TIMING = 2'b01,
    OT_ALARM = 2'b11,
    OT_TRIP = 2'b10
  } ot_state_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] dc_voltage;
    logic ramp_accel;
    logic ramp_const;
    logic ramp_decel;
    logic running;
    logic freq_reached;
    logic valid;
  } meas_t;

  typedef struct packed {
    logic [3:0] step;
    logic [15:0] elapsed;
  } prog_t;

  typedef struct packed {
    logic ramp_hold;
    logic freq_reduce;
    logic [15:0] reduce_time;
    logic alarm;
    logic trip;
  } drive_cmd_t;

endpackage

// ### rtl/tenth_second_tick.sv
// Periodic one-cycle tick for over-torque timing
`timescale 1ns/1ps
module tenth_second_tick #(
  parameter int unsigned CYCLES = 20000000
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  output logic o_tick
);
  logic [31:0] cnt_q;
  wire last = (cnt_q == 32'(CYCLES - 1));

  always_ff @(posedge i_mclk) begin
    if (i_reset || last) begin
      cnt_q <= 32'h00000000;
    end else begin
      cnt_q <= cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= last;
    end
  end
endmodule // tenth_second_tick

// ### rtl/drive_stall_overtorque_supervisor.sv
// Stall prevention, over-torque supervision and step program storage
`timescale 1ns/1ps
module drive_stall_overtorque_supervisor #(
  parameter int unsigned TICK_CYCLES = drive_supervisor_pkg::OT_STEP_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire drive_supervisor_pkg::meas_t i_meas,
  input wire drive_supervisor_pkg::prog_t i_prog,
  input wire logic i_stop,
  input wire logic i_fault,
  output logic [31:0] o_rdata,
  output drive_supervisor_pkg::drive_cmd_t o_cmd,
  output drive_supervisor_pkg::prog_t o_resume,
  output logic o_resume_valid,
  output logic [3:0] o_next_step,
  output logic o_irq
);
  import drive_supervisor_pkg::*;

  // ************
  // Helpers
  // ************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic over_level(input logic [15:0] cur, input logic [7:0] lvl,
                                      input logic [15:0] rated);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(cur) * PCT_FULL;
    rhs = 24'(lvl) * 24'(rated);
    return (lvl != 8'h00) && (lhs > rhs);
  endfunction

  // ************
  // Configuration registers
  // ************
  logic [6:0] ctrl_q;
  logic [7:0] accel_lvl_q;
  logic [7:0] const_lvl_q;
  logic [7:0] decel_lvl_q;
  logic [7:0] ot_lvl_q;
  logic [7:0] ot_time_q;
  logic [15:0] stall_dec_q;
  logic [15:0] rated_q;
  logic [15:0] ov_volt_q;
  logic [NUM_EV-1:0] irq_en_q;
  logic [NUM_EV-1:0] status_q;
  logic [15:0] freq_q [NUM_FREQ];
  logic [15:0] timer_q [NUM_TIMER];

  wire ov_en = ctrl_q[CTRL_OV_EN];
  wire [1:0] ot_mode = ctrl_q[CTRL_OT_MODE +: 2];
  wire retain = ctrl_q[CTRL_RETAIN];
  wire [2:0] ms_mode = ctrl_q[CTRL_MS_MODE +: 3];

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q <= CTRL_RST;
      accel_lvl_q <= ACCEL_LVL_RST;
      const_lvl_q <= CONST_LVL_RST;
      decel_lvl_q <= DECEL_LVL_RST;
      ot_lvl_q <= OT_LVL_RST;
      ot_time_q <= OT_TIME_RST;
    end else if (i_wr) begin
      if (hit(i_addr, OFF_CTRL)) ctrl_q <= i_wdata[6:0];
      if (hit(i_addr, OFF_ACCEL_LVL)) accel_lvl_q <= i_wdata[7:0];
      if (hit(i_addr, OFF_CONST_LVL)) const_lvl_q <= i_wdata[7:0];
      if (hit(i_addr, OFF_DECEL_LVL)) decel_lvl_q <= i_wdata[7:0];
      if (hit(i_addr, OFF_OT_LVL)) ot_lvl_q <= i_wdata[7:0];
      if (hit(i_addr, OFF_OT_TIME)) ot_time_q <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      stall_dec_q <= STALL_DEC_RST;
      rated_q <= RATED_CUR_RST;
      ov_volt_q <= OV_VOLT_RST;
      irq_en_q <= '0;
    end else if (i_wr) begin
      if (hit(i_addr, OFF_STALL_DEC)) stall_dec_q <= i_wdata[15:0];
      if (hit(i_addr, OFF_RATED_CUR)) rated_q <= i_wdata[15:0];
      if (hit(i_addr, OFF_OV_VOLT)) ov_volt_q <= i_wdata[15:0];
      if (hit(i_addr, OFF_IRQ_EN)) irq_en_q <= i_wdata[NUM_EV-1:0];
    end
  end

  // ************
  // Step tables
  // ************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FREQ; gi++) begin : g_freq
      wire sel = hit(i_addr, OFF_FREQ_BASE + 8'(gi * 4));
      always_ff @(posedge i_mclk) begin
        if (i_reset) begin
          freq_q[gi] <= FREQ_RST[gi];
        end else if (i_wr && sel) begin
          freq_q[gi] <= i_wdata[15:0];
        end
      end
    end
    for (gi = 0; gi < NUM_TIMER; gi++) begin : g_timer
      wire sel = hit(i_addr, OFF_TIMER_BASE + 8'(gi * 4));
      always_ff @(posedge i_mclk) begin
        if (i_reset) begin
          timer_q[gi] <= TIMER_RST[gi];
        end else if (i_wr && sel) begin
          timer_q[gi] <= i_wdata[15:0];
        end
      end
    end
  endgenerate

  // ************
  // Stall prevention
  // ************
  wire over_acc = over_level(i_meas.current, accel_lvl_q, rated_q);
  wire over_const = over_level(i_meas.current, const_lvl_q, rated_q);
  wire over_dec = over_level(i_meas.current, decel_lvl_q, rated_q);
  wire ov_hit = ov_en && i_meas.ramp_decel && (i_meas.dc_voltage > ov_volt_q);
  wire acc_hit = i_meas.ramp_accel && over_acc;
  wire dec_hit = i_meas.ramp_decel && over_dec;
  wire hold_d = ov_hit || acc_hit || dec_hit;
  wire reduce_d = i_meas.ramp_const && over_const;

  logic hold_q;
  logic reduce_q;
  logic ov_q;
  logic acc_q;
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      hold_q <= 1'b0;
      reduce_q <= 1'b0;
      ov_q <= 1'b0;
      acc_q <= 1'b0;
    end else if (i_meas.valid) begin
      hold_q <= hold_d;
      reduce_q <= reduce_d;
      ov_q <= ov_hit;
      acc_q <= acc_hit;
    end
  end

  // ************
  // Over-torque timing
  // ************
  logic tick;
  tenth_second_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .o_tick(tick)
  );

  ot_state_t ot_q;
  ot_state_t ot_d;
  logic [7:0] ot_cnt_q;
  logic ot_over_q;
  wire ot_window = ot_mode[1] || i_meas.freq_reached;
  wire ot_over = i_meas.running && ot_window &&
                 over_level(i_meas.current, ot_lvl_q, rated_q);
  wire ot_stop = ot_mode[0];
  wire past_half = {ot_cnt_q, 1'b0} > {1'b0, ot_time_q};
  wire past_full = ot_cnt_q > ot_time_q;
  wire trip_clr = i_wr && hit(i_addr, OFF_IRQ_CLR) && i_wdata[EV_OT_TRIP];

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ot_over_q <= 1'b0;
    end else if (i_meas.valid) begin
      ot_over_q <= ot_over;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || !ot_over_q || ot_q == OT_TRIP) begin
      ot_cnt_q <= 8'h00;
    end else if (tick && ot_cnt_q != 8'hFF) begin
      ot_cnt_q <= ot_cnt_q + 8'h01;
    end
  end

  always_comb begin
    ot_d = ot_q;
    unique case (ot_q)
      OT_IDLE: begin
        if (ot_over_q) ot_d = OT_TIMING;
      end
      OT_TIMING: begin
        if (!ot_over_q) ot_d = OT_IDLE;
        else if (past_half) ot_d = OT_ALARM;
      end
      OT_ALARM: begin
        if (!ot_over_q) ot_d = OT_IDLE;
        else if (past_full && ot_stop) ot_d = OT_TRIP;
      end
      OT_TRIP: begin
        if (trip_clr) ot_d = OT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ot_q <= OT_IDLE;
    end else begin
      ot_q <= ot_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_cmd <= '0;
    end else begin
      o_cmd.ramp_hold <= hold_q && ot_q != OT_TRIP;
      o_cmd.freq_reduce <= reduce_q && ot_q != OT_TRIP;
      o_cmd.reduce_time <= stall_dec_q;
      o_cmd.alarm <= ot_q == OT_ALARM || ot_q == OT_TRIP;
      o_cmd.trip <= ot_q == OT_TRIP;
    end
  end

  // ************
  // Program state retention
  // ************
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_resume <= '0;
      o_resume_valid <= 1'b0;
    end else if (!retain) begin
      o_resume <= '0;
      o_resume_valid <= 1'b0;
    end else if (i_stop || i_fault) begin
      o_resume <= i_prog;
      o_resume_valid <= 1'b1;
    end
  end

  // Next step with a nonzero timer, wrapping
  function automatic logic [3:0] next_step(input logic [3:0] cur);
    logic [3:0] res;
    logic found;
    logic [3:0] idx;
    res = cur;
    found = 1'b0;
    for (int k = 1; k <= NUM_TIMER; k++) begin
      idx = 4'(cur + 4'(k));
      if (!found && timer_q[idx] != 16'h0000) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  wire [3:0] step_d = (ms_mode == MS_INTERNAL) ? next_step(i_prog.step) : i_prog.step;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_next_step <= 4'h0;
    end else begin
      o_next_step <= step_d;
    end
  end

  // ************
  // Interrupts
  // ************
  wire saved_ev = retain && (i_stop || i_fault);
  wire [NUM_EV-1:0] ev = {saved_ev,
                          ot_d == OT_TRIP && ot_q != OT_TRIP,
                          ot_d == OT_ALARM && ot_q == OT_TIMING,
                          reduce_d && i_meas.valid && !reduce_q,
                          acc_hit && i_meas.valid && !acc_q,
                          ov_hit && i_meas.valid && !ov_q};
  wire [NUM_EV-1:0] clr = (i_wr && hit(i_addr, OFF_IRQ_CLR)) ?
                          i_wdata[NUM_EV-1:0] : '0;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      status_q <= '0;
      o_irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      o_irq <= |(((status_q & ~clr) | ev) & irq_en_q);
    end
  end

  // ************
  // Read port
  // ************
  logic [31:0] rd_d;
  logic [15:0] tbl_rd;
  wire [3:0] tbl_idx = i_addr[5:2];

  always_comb begin
    tbl_rd = 16'h0000;
    if (i_addr[7:6] == 2'b10) begin
      tbl_rd = timer_q[tbl_idx];
    end else if (i_addr[7:6] == 2'b01 && tbl_idx != 4'hF) begin
      tbl_rd = freq_q[tbl_idx];
    end
  end

  always_comb begin
    rd_d = 32'h00000000;
    if (i_addr[1:0] == 2'b00) begin
      unique case (i_addr)
        OFF_CTRL: rd_d = 32'(ctrl_q);
        OFF_ACCEL_LVL: rd_d = 32'(accel_lvl_q);
        OFF_CONST_LVL: rd_d = 32'(const_lvl_q);
        OFF_DECEL_LVL: rd_d = 32'(decel_lvl_q);
        OFF_OT_LVL: rd_d = 32'(ot_lvl_q);
        OFF_OT_TIME: rd_d = 32'(ot_time_q);
        OFF_STALL_DEC: rd_d = 32'(stall_dec_q);
        OFF_RATED_CUR: rd_d = 32'(rated_q);
        OFF_OV_VOLT: rd_d = 32'(ov_volt_q);
        OFF_STATUS: rd_d = 32'(status_q);
        OFF_IRQ_EN: rd_d = 32'(irq_en_q);
        OFF_MONITOR: rd_d = {20'h00000, ot_cnt_q, reduce_q, hold_q, ot_q};
        OFF_SAVED: rd_d = {11'h000, o_resume_valid, o_resume};
        default: rd_d = 32'(tbl_rd);
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule // drive_stall_overtorque_supervisor

// ### verification/drive_supervisor_assertions.sv
// Port-level checks on the drive supervisor
`timescale 1ns/1ps
module drive_supervisor_assertions #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire drive_supervisor_pkg::meas_t i_meas,
  input wire drive_supervisor_pkg::prog_t i_prog,
  input wire logic i_stop,
  input wire logic i_fault,
  input wire logic [31:0] o_rdata,
  input wire drive_supervisor_pkg::drive_cmd_t o_cmd,
  input wire drive_supervisor_pkg::prog_t o_resume,
  input wire logic o_resume_valid,
  input wire logic [3:0] o_next_step,
  input wire logic o_irq
);
  import drive_supervisor_pkg::*;
  wire clr_trip = i_wr && i_addr == OFF_IRQ_CLR && i_wdata[EV_OT_TRIP];
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);
  sequence trip_held_s;
    o_cmd.trip && !clr_trip && !$past(clr_trip);
  endsequence
  sequence trip_two_s;
    o_cmd.trip ##1 o_cmd.trip;
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read cycle");
  // Leaving trip lets a held command through again
  a_hold_cause: assert property (
    $rose(o_cmd.ramp_hold) |-> $past(o_cmd.trip) || $past(i_meas.valid, 2) &&
      ($past(i_meas.ramp_accel, 2) || $past(i_meas.ramp_decel, 2)))
    else $error("ramp hold without ramp update");
  a_reduce_cause: assert property (
    $rose(o_cmd.freq_reduce) |-> $past(o_cmd.trip) ||
      $past(i_meas.valid, 2) && $past(i_meas.ramp_const, 2))
    else $error("reduce without constant-speed update");
  a_trip_quiet: assert property (
    trip_two_s |-> !o_cmd.ramp_hold && !o_cmd.freq_reduce)
    else $error("ramp command during trip");
  a_trip_after_alarm: assert property (
    $rose(o_cmd.trip) |-> o_cmd.alarm && $past(o_cmd.alarm))
    else $error("trip without earlier alarm");
  a_trip_sticky: assert property (trip_held_s |=> o_cmd.trip)
    else $error("trip dropped without clear");
  a_resume_cause: assert property (
    $rose(o_resume_valid) |-> $past(i_stop || i_fault) && o_resume == $past(i_prog))
    else $error("resume state not captured at halt");
  a_resume_hold: assert property (
    !$past(i_stop) && !$past(i_fault) && !$past(i_wr) && !$past(i_wr, 2) |->
      $stable(o_resume) && $stable(o_resume_valid))
    else $error("resume state changed without cause");
endmodule // drive_supervisor_assertions

bind drive_stall_overtorque_supervisor drive_supervisor_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) i_drive_supervisor_assertions (.i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_meas, .i_prog, .i_stop, .i_fault, .o_rdata, .o_cmd, .o_resume, .o_resume_valid,
  .o_next_step, .o_irq);

// ### verification/drive_meas_model.sv
// Ramp state and measurement source standing in for the inverter
`timescale 1ns/1ps
module drive_meas_model (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [15:0] i_cur,
  input wire logic [15:0] i_volt,
  input wire logic [1:0] i_phase,
  input wire logic i_slow,
  output drive_supervisor_pkg::meas_t o_meas
);
  import drive_supervisor_pkg::*;
  logic [1:0] cnt_q = 2'h0;
  meas_t meas_q = '0;
  assign o_meas = meas_q;
  // Phase 1 accel, 2 constant at set frequency, 3 decel
  always_ff @(posedge i_mclk) begin
    cnt_q <= i_reset ? 2'h0 : cnt_q + 2'h1;
    meas_q <= '{i_cur, i_volt, i_phase == 2'h1, i_phase == 2'h2, i_phase == 2'h3,
      1'b1, i_phase == 2'h2, !i_reset && (!i_slow || cnt_q == 2'h0)};
  end
endmodule // drive_meas_model

// ### verification/drive_stall_overtorque_supervisor_tb_top.sv
// Self-checking bench for the drive supervisor
`timescale 1ns/1ps
module drive_stall_overtorque_supervisor_tb_top;
  import drive_supervisor_pkg::*;
  localparam logic [7:0] RA [17] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
    8'h1C, 8'h20, 8'h40, 8'h58, 8'h78, 8'h80, 8'h84, 8'h88, 8'hBC, 8'h3C};
  localparam logic [31:0] RE [17] = '{32'h1, 32'h96, 32'h0, 32'h96, 32'h0, 32'h0A,
    32'h32, 32'h64, 32'h320, 32'h5DC, 32'h32, 32'h1194, 32'h64, 32'h64, 32'h0, 32'h0, 32'h0};
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  meas_t i_meas;
  prog_t i_prog = '0;
  logic i_stop = 1'b0;
  logic i_fault = 1'b0;
  logic [31:0] o_rdata;
  drive_cmd_t o_cmd;
  prog_t o_resume;
  logic o_resume_valid;
  logic [3:0] o_next_step;
  logic o_irq;
  logic [15:0] cur = 16'h0;
  logic [15:0] volt = 16'h0;
  logic [1:0] phase = 2'h0;
  logic slow = 1'b0;
  logic [31:0] got;
  logic [31:0] rv;
  prog_t p;
  logic al;
  int n;
  int lv;
  int rt;
  int c;
  int v;
  int failures = 0;
  int check_count = 0;
  always #2.5 i_mclk = ~i_mclk;
  drive_meas_model i_drive_meas_model (.i_mclk, .i_reset, .i_cur(cur), .i_volt(volt),
    .i_phase(phase), .i_slow(slow), .o_meas(i_meas));
  drive_stall_overtorque_supervisor #(.TICK_CYCLES(8)) i_drive_stall_overtorque_supervisor (
    .i_mclk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_meas, .i_prog, .i_stop,
    .i_fault, .o_rdata, .o_cmd, .o_resume, .o_resume_valid, .o_next_step, .o_irq);
  function automatic logic over(input int c_in, input int l_in, input int r_in);
    return l_in != 0 && c_in * 100 > l_in * r_in;
  endfunction
  task automatic wrap_up();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic meas(input logic [15:0] c_in, input logic [15:0] v_in, input logic [1:0] ph);
    @(posedge i_mclk);
    cur <= c_in;
    volt <= v_in;
    phase <= ph;
  endtask
  task automatic wait_cmd(input int sel, input int bound);
    n = 0;
    while (n < bound && o_cmd[sel] !== 1'b1) begin
      cyc(1);
      n++;
    end
    if (o_cmd[sel] !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic halt(input logic f);
    @(posedge i_mclk);
    p = 20'($urandom);
    i_prog <= p;
    i_stop <= !f;
    i_fault <= f;
    @(posedge i_mclk);
    i_stop <= 1'b0;
    i_fault <= 1'b0;
    #1;
  endtask
  task automatic nstep(input logic [3:0] s, input logic [3:0] e);
    @(posedge i_mclk);
    i_prog.step <= s;
    cyc(3);
    chk(o_next_step, e);
  endtask
  initial begin
    rv = $urandom(75);
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    foreach (RA[k]) begin
      rd(RA[k], got);
      chk(got, RE[k]);
    end
    repeat (8) begin
      n = $urandom_range(14);
      rv = $urandom_range(40000);
      wr(8'(8'h40 + 4 * n), rv);
      rd(8'(8'h40 + 4 * n), got);
      chk(got, rv);
    end
    // Accel, constant and decel current levels
    for (int ph = 1; ph < 4; ph++) begin
      for (int k = 0; k < 6; k++) begin
        lv = (k == 2) ? 0 : (k < 2) ? 150 : $urandom_range(200);
        rt = (k < 3) ? 100 : $urandom_range(200, 1);
        c = (k == 0) ? 151 : (k == 1) ? 150 : (k == 2) ? 300 : $urandom_range(400);
        slow <= k[0];
        wr(8'(4 * ph), 32'(lv));
        wr(OFF_RATED_CUR, 32'(rt));
        meas(16'(c), 16'd100, 2'(ph));
        cyc(8);
        al = over(c, lv, rt);
        chk({o_cmd.ramp_hold, o_cmd.freq_reduce}, {al && ph != 2, al && ph == 2});
        if (al && ph == 2) chk(o_cmd.reduce_time, 32'h32);
      end
    end
    wr(OFF_RATED_CUR, 32'd100);
    wr(OFF_DECEL_LVL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 801 : (k == 1) ? 800 : (k == 2) ? 900 : $urandom_range(1000, 600);
      wr(OFF_CTRL, 32'(k != 2));
      meas(16'd50, 16'(v), 2'h3);
      cyc(8);
      chk(o_cmd.ramp_hold, k != 2 && v > 800);
    end
    // Over-torque modes, before and at set frequency
    wr(OFF_OT_LVL, 32'd120);
    for (int m = 0; m < 8; m++) begin
      al = m > 3 || m % 4 >= 2;
      wr(OFF_IRQ_EN, (m % 4 == 3) ? 32'h0 : 32'h8);
      wr(OFF_CTRL, 32'(2 * (m % 4)));
      meas(16'd130, 16'd100, (m > 3) ? 2'h2 : 2'h1);
      cyc(30);
      chk(o_cmd.alarm, 1'b0);
      if (al) begin
        wait_cmd(1, 80);
        chk(30 + n >= 40, 1'b1);
        chk(o_irq, m % 4 != 3);
        if (m % 2) begin
          wait_cmd(0, 60);
          chk(n >= 36, 1'b1);
        end else begin
          cyc(60);
          chk(o_cmd.trip, 1'b0);
        end
      end else begin
        cyc(60);
        chk({o_cmd.alarm, o_cmd.trip}, 2'h0);
      end
      meas(16'd50, 16'd100, 2'h2);
      cyc(8);
      chk(o_cmd.trip, al && m % 2);
      rd(OFF_STATUS, got);
      chk(got[3], al);
      wr(OFF_IRQ_CLR, 32'h3F);
      cyc(3);
      chk({o_cmd.alarm, o_cmd.trip, o_irq}, 3'h0);
    end
    wr(OFF_OT_LVL, 32'h0);
    wr(OFF_CTRL, 32'h4);
    meas(16'd300, 16'd100, 2'h2);
    cyc(100);
    chk(o_cmd.alarm, 1'b0);
    wr(OFF_CTRL, 32'h8);
    halt(1'b0);
    chk({o_resume_valid, o_resume}, {1'b1, p});
    rd(OFF_SAVED, got);
    chk(got, 32'({1'b1, p}));
    wr(OFF_CTRL, 32'h0);
    halt(1'b1);
    chk(o_resume_valid, 1'b0);
    wr(OFF_CTRL, 32'h10);
    nstep(4'h0, 4'h1);
    nstep(4'h1, 4'h0);
    nstep(4'hF, 4'h0);
    wr(8'h90, 32'h7);
    rd(8'h90, got);
    chk(got, 32'h7);
    nstep(4'h1, 4'h4);
    nstep(4'h4, 4'h0);
    wr(OFF_CTRL, 32'h0);
    nstep(4'h9, 4'h9);
    wrap_up();
  end
endmodule // drive_stall_overtorque_supervisor_tb_top
